// File: common/cbs_pkg.sv
// Constants for the secondary status and bus number register block
package cbs_pkg;

  // Configuration dword offsets (byte addresses, dword aligned)
  localparam logic [7:0] CBS_OFS_STATUS_DW  = 8'h14;
  localparam logic [7:0] CBS_OFS_BUSNUM_DW  = 8'h18;

  // Printed byte offsets of the bus number registers
  localparam logic [7:0] CBS_OFS_PRIMARY    = 8'h18;
  localparam logic [7:0] CBS_OFS_SECONDARY  = 8'h19;
  localparam logic [7:0] CBS_OFS_SUBORD     = 8'h1A;

  // Byte lanes inside the addressed dword
  localparam int unsigned CBS_LANE_PRIMARY   = 0;
  localparam int unsigned CBS_LANE_SECONDARY = 1;
  localparam int unsigned CBS_LANE_SUBORD    = 2;
  localparam int unsigned CBS_LANE_STAT_LO   = 2;
  localparam int unsigned CBS_LANE_STAT_HI   = 3;

  // Secondary status sits in the upper half of its dword
  localparam int unsigned CBS_STATUS_SHIFT  = 16;

  // Secondary status field positions
  localparam int unsigned CBS_BIT_PARITY    = 15;
  localparam int unsigned CBS_BIT_SERR      = 14;
  localparam int unsigned CBS_BIT_MABORT    = 13;
  localparam int unsigned CBS_BIT_TABORT_RX = 12;
  localparam int unsigned CBS_BIT_TABORT_TX = 11;
  localparam int unsigned CBS_BIT_TIMING_HI = 10;
  localparam int unsigned CBS_BIT_TIMING_LO = 9;
  localparam int unsigned CBS_BIT_DPAR      = 8;
  localparam int unsigned CBS_BIT_B2B       = 7;
  localparam int unsigned CBS_BIT_UDF       = 6;
  localparam int unsigned CBS_BIT_DSPEED    = 5;

  // Hardwired field values
  localparam logic [1:0] CBS_DEVSEL_MEDIUM  = 2'h1;
  localparam logic       CBS_B2B_VALUE      = 1'b0;
  localparam logic       CBS_UDF_VALUE      = 1'b0;
  localparam logic       CBS_DSPEED_VALUE   = 1'b0;
  localparam logic [4:0] CBS_RSVD_VALUE     = 5'h00;

  // Reset values
  localparam logic [7:0] CBS_BUSNUM_RESET   = 8'h00;
  localparam logic       CBS_FLAG_RESET     = 1'b0;

  // Number of sticky error flags
  localparam int unsigned CBS_NUM_FLAGS     = 6;

  // Index of each flag in the flag vector
  localparam int unsigned CBS_FI_DPAR       = 0;
  localparam int unsigned CBS_FI_TABORT_TX  = 1;
  localparam int unsigned CBS_FI_TABORT_RX  = 2;
  localparam int unsigned CBS_FI_MABORT     = 3;
  localparam int unsigned CBS_FI_SERR       = 4;
  localparam int unsigned CBS_FI_PARITY     = 5;

endpackage

// File: hw/cbs_sticky_flag.sv
// One sticky status flag, set by hardware, cleared by write-one
`timescale 1ns/1ps
module cbs_sticky_flag
  import cbs_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic global_reset_n,
  input  wire logic set_evt,
  input  wire logic clr_req,
  output logic      flag_r
);

  // Of the resets, only the global reset clears; set wins over a same-cycle clear
  always_ff @(posedge core_clk) begin
    if (!global_reset_n) begin
      flag_r <= CBS_FLAG_RESET;
    end else if (set_evt) begin
      flag_r <= 1'b1;
    end else if (clr_req) begin
      flag_r <= 1'b0;
    end
  end

endmodule

// File: hw/cbs_bridge_regs.sv
// Secondary status and bus number configuration registers of the bridge
//
// What this block does
// - Bit 15 set on secondary parity error
// - Bit 14 set on card system error
// - Card system error line never driven here
// - Bit 13 set on received master abort
// - Bit 12 set on received target abort
// - Bit 11 set on signaled target abort
// - Error flags clear on write of one
// - Bits 10 to 9 read 01b
// - Bit 8 needs parity error, master, enable
// - Bit 7 always reads zero
// - Bit 6 always reads zero
// - Bit 5 always reads zero
// - Bits 4 to 0 read zero
// - Of the two resets, only global reset clears error flags
// - Primary bus number at 18h, reset 00h
// - Secondary bus number at 19h, reset 00h
// - Forwarding decided from secondary and subordinate numbers only
// - Subordinate bus number at 1Ah
`timescale 1ns/1ps
module cbs_bridge_regs
  import cbs_pkg::*;
#(
  parameter int unsigned BUS_W = 8
)
(
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire logic             global_reset_n,
  input  wire logic             cfg_wr,
  input  wire logic             cfg_rd,
  input  wire logic [7:0]       cfg_addr,
  input  wire logic [3:0]       cfg_be,
  input  wire logic [31:0]      cfg_wdata,
  output logic      [31:0]      cfg_rdata,
  output logic                  cfg_rvalid,
  input  wire logic             sec_parity_err,
  input  wire logic             card_serr_n,
  input  wire logic             sec_master_abort,
  input  wire logic             sec_target_abort_in,
  input  wire logic             sec_target_abort_out,
  input  wire logic             card_perr_n,
  input  wire logic             sec_was_master,
  input  wire logic             parity_resp_en,
  input  wire logic             fwd_req,
  input  wire logic [BUS_W-1:0] fwd_bus,
  output logic                  fwd_local,
  output logic                  fwd_pass,
  output logic                  fwd_drop,
  output logic      [15:0]      sec_status
);

  logic [BUS_W-1:0]         primary_bus_number_r;
  logic [BUS_W-1:0]         secondary_bus_number_r;
  logic [BUS_W-1:0]         subordinate_bus_number_r;
  logic [CBS_NUM_FLAGS-1:0] flag_set;
  logic [CBS_NUM_FLAGS-1:0] flag_clr;
  logic [CBS_NUM_FLAGS-1:0] flag_r;
  logic                     hit_status;
  logic                     hit_busnum;
  logic                     wr_hi;
  logic [7:0]               w1c_byte;
  logic [15:0]              status_val;
  logic [31:0]              rdata_nxt;
  logic                     sec_parity_detected;
  logic                     sec_system_error_seen;
  logic                     sec_master_abort_received;
  logic                     sec_target_abort_received;
  logic                     sec_target_abort_signaled;
  logic                     sec_data_parity_reported;
  logic [1:0]               sec_devsel_timing;
  logic                     sec_back_to_back_capable;
  logic                     sec_user_feature_support;
  logic                     sec_double_speed_capable;

  assign hit_status = (cfg_addr == CBS_OFS_STATUS_DW);
  assign hit_busnum = (cfg_addr == CBS_OFS_BUSNUM_DW);

  // Every flag of bits 15..8 lives in the top byte lane
  assign wr_hi    = cfg_wr && hit_status && cfg_be[CBS_LANE_STAT_HI];
  assign w1c_byte = wr_hi ? cfg_wdata[31:24] : 8'h00;

  assign flag_set[CBS_FI_PARITY]    = sec_parity_err;
  assign flag_set[CBS_FI_SERR]      = !card_serr_n;
  assign flag_set[CBS_FI_MABORT]    = sec_master_abort;
  assign flag_set[CBS_FI_TABORT_RX] = sec_target_abort_in;
  assign flag_set[CBS_FI_TABORT_TX] = sec_target_abort_out;
  assign flag_set[CBS_FI_DPAR]      = !card_perr_n && sec_was_master && parity_resp_en;

  assign flag_clr[CBS_FI_PARITY]    = w1c_byte[CBS_BIT_PARITY - 8];
  assign flag_clr[CBS_FI_SERR]      = w1c_byte[CBS_BIT_SERR - 8];
  assign flag_clr[CBS_FI_MABORT]    = w1c_byte[CBS_BIT_MABORT - 8];
  assign flag_clr[CBS_FI_TABORT_RX] = w1c_byte[CBS_BIT_TABORT_RX - 8];
  assign flag_clr[CBS_FI_TABORT_TX] = w1c_byte[CBS_BIT_TABORT_TX - 8];
  assign flag_clr[CBS_FI_DPAR]      = w1c_byte[CBS_BIT_DPAR - 8];

  genvar gi;
  generate
    for (gi = 0; gi < CBS_NUM_FLAGS; gi++) begin : g_flag
      cbs_sticky_flag u_flag (
        .core_clk       (core_clk),
        .global_reset_n (global_reset_n),
        .set_evt        (flag_set[gi]),
        .clr_req        (flag_clr[gi]),
        .flag_r         (flag_r[gi])
      );
    end
  endgenerate

  assign sec_parity_detected       = flag_r[CBS_FI_PARITY];
  assign sec_system_error_seen     = flag_r[CBS_FI_SERR];
  assign sec_master_abort_received = flag_r[CBS_FI_MABORT];
  assign sec_target_abort_received = flag_r[CBS_FI_TABORT_RX];
  assign sec_target_abort_signaled = flag_r[CBS_FI_TABORT_TX];
  assign sec_data_parity_reported  = flag_r[CBS_FI_DPAR];

  assign sec_devsel_timing        = CBS_DEVSEL_MEDIUM;
  assign sec_back_to_back_capable = CBS_B2B_VALUE;
  assign sec_user_feature_support = CBS_UDF_VALUE;
  assign sec_double_speed_capable = CBS_DSPEED_VALUE;

  assign status_val = {sec_parity_detected, sec_system_error_seen,
                       sec_master_abort_received, sec_target_abort_received,
                       sec_target_abort_signaled, sec_devsel_timing,
                       sec_data_parity_reported, sec_back_to_back_capable,
                       sec_user_feature_support, sec_double_speed_capable,
                       CBS_RSVD_VALUE};

  assign sec_status = status_val;

  always_ff @(posedge core_clk) begin
    if (!rst_b || !global_reset_n) begin
      primary_bus_number_r <= BUS_W'(CBS_BUSNUM_RESET);
    end else if (cfg_wr && hit_busnum && cfg_be[CBS_LANE_PRIMARY]) begin
      primary_bus_number_r <= cfg_wdata[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b || !global_reset_n) begin
      secondary_bus_number_r <= BUS_W'(CBS_BUSNUM_RESET);
    end else if (cfg_wr && hit_busnum && cfg_be[CBS_LANE_SECONDARY]) begin
      secondary_bus_number_r <= cfg_wdata[15:8];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b || !global_reset_n) begin
      subordinate_bus_number_r <= BUS_W'(CBS_BUSNUM_RESET);
    end else if (cfg_wr && hit_busnum && cfg_be[CBS_LANE_SUBORD]) begin
      subordinate_bus_number_r <= cfg_wdata[23:16];
    end
  end

  // Unmapped dwords and unused lanes read as zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (hit_status) begin
      rdata_nxt[31:16] = status_val;
    end else if (hit_busnum) begin
      rdata_nxt[7:0]   = primary_bus_number_r;
      rdata_nxt[15:8]  = secondary_bus_number_r;
      rdata_nxt[23:16] = subordinate_bus_number_r;
    end
  end

  // Read data is captured so it stays stable for the host
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cfg_rdata  <= 32'h0000_0000;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd) begin
        cfg_rdata <= rdata_nxt;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      fwd_local <= 1'b0;
      fwd_pass  <= 1'b0;
      fwd_drop  <= 1'b0;
    end else begin
      fwd_local <= fwd_req && (fwd_bus == secondary_bus_number_r);
      fwd_pass  <= fwd_req && (fwd_bus > secondary_bus_number_r)
                   && (fwd_bus <= subordinate_bus_number_r);
      fwd_drop  <= fwd_req && !((fwd_bus == secondary_bus_number_r)
                   || ((fwd_bus > secondary_bus_number_r)
                   && (fwd_bus <= subordinate_bus_number_r)));
    end
  end

  // Primary number is not compared: a bus equal to it is upstream, hence dropped
  // by the range test as long as software keeps primary below secondary.

  a_parity_sets: assert property (
    @(posedge core_clk) disable iff (!global_reset_n)
    sec_parity_err |=> sec_status[CBS_BIT_PARITY])
    else $error("parity flag not set after event");

  a_serr_sets: assert property (
    @(posedge core_clk) disable iff (!global_reset_n)
    !card_serr_n |=> sec_status[CBS_BIT_SERR])
    else $error("system error flag not set");

  a_mabort_sets: assert property (
    @(posedge core_clk) disable iff (!global_reset_n)
    sec_master_abort |=> sec_status[CBS_BIT_MABORT])
    else $error("master abort flag not set");

  a_tabort_rx_sets: assert property (
    @(posedge core_clk) disable iff (!global_reset_n)
    sec_target_abort_in |=> sec_status[CBS_BIT_TABORT_RX])
    else $error("received target abort flag not set");

  a_tabort_tx_sets: assert property (
    @(posedge core_clk) disable iff (!global_reset_n)
    sec_target_abort_out |=> sec_status[CBS_BIT_TABORT_TX])
    else $error("signaled target abort flag not set");

  a_w1c_clears: assert property (
    @(posedge core_clk) disable iff (!global_reset_n)
    (wr_hi && cfg_wdata[31] && !sec_parity_err) |=> !sec_status[CBS_BIT_PARITY])
    else $error("write one did not clear parity flag");

  a_timing_fixed: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    cfg_rvalid && $past(cfg_addr) == CBS_OFS_STATUS_DW |->
      cfg_rdata[26:25] == CBS_DEVSEL_MEDIUM && cfg_rdata[23:16] == 8'h00)
    else $error("hardwired status field wrong");

  a_dpar_gated: assert property (
    @(posedge core_clk) disable iff (!global_reset_n)
    (!sec_status[CBS_BIT_DPAR] && !(!card_perr_n && sec_was_master && parity_resp_en))
      |=> !sec_status[CBS_BIT_DPAR])
    else $error("data parity flag set without cause");

  a_low_bits_zero: assert property (
    @(posedge core_clk) sec_status[7:0] == 8'h00)
    else $error("status bits 7 to 0 not zero");

  a_flags_hold: assert property (
    @(posedge core_clk) disable iff (!global_reset_n)
    (!wr_hi && flag_set == '0) |=> $stable(flag_r))
    else $error("flags changed without write or event");

  a_primary_write: assert property (
    @(posedge core_clk) disable iff (!rst_b || !global_reset_n)
    (cfg_wr && hit_busnum && cfg_be[0]) ##1 (cfg_rd && hit_busnum && !cfg_wr)
      |=> cfg_rdata[7:0] == $past(cfg_wdata[7:0], 2))
    else $error("primary bus number not stored");

  a_fwd_onehot: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    fwd_req |=> $onehot({fwd_local, fwd_pass, fwd_drop}))
    else $error("forward decision not exactly one");

  a_fwd_local: assert property (
    @(posedge core_clk) disable iff (!rst_b || !global_reset_n)
    (fwd_req && fwd_bus == secondary_bus_number_r) |=> fwd_local && !fwd_pass)
    else $error("local card access not selected");

  a_dpar_sets: assert property (
    @(posedge core_clk) disable iff (!global_reset_n)
    (!card_perr_n && sec_was_master && parity_resp_en) |=> sec_status[CBS_BIT_DPAR])
    else $error("data parity flag not set");

  a_dpar_clears: assert property (
    @(posedge core_clk) disable iff (!global_reset_n)
    (wr_hi && cfg_wdata[CBS_BIT_DPAR + CBS_STATUS_SHIFT] && !flag_set[CBS_FI_DPAR])
      |=> !sec_status[CBS_BIT_DPAR])
    else $error("write one did not clear data parity flag");

  a_zero_write_keeps: assert property (
    @(posedge core_clk) disable iff (!global_reset_n)
    (wr_hi && cfg_wdata[31:24] == 8'h00 && flag_set == '0) |=> $stable(sec_status))
    else $error("zero write changed status");

  a_flags_global_clear: assert property (
    @(posedge core_clk)
    !global_reset_n |=> flag_r == {CBS_NUM_FLAGS{CBS_FLAG_RESET}})
    else $error("global reset did not clear flags");

  a_local_reset_keeps: assert property (
    @(posedge core_clk) disable iff (!global_reset_n)
    (!rst_b && !wr_hi) |=> flag_r == ($past(flag_r) | $past(flag_set)))
    else $error("local reset disturbed error flags");

  a_busnum_reset: assert property (
    @(posedge core_clk)
    (!rst_b || !global_reset_n) |=> primary_bus_number_r == BUS_W'(CBS_BUSNUM_RESET)
      && secondary_bus_number_r == BUS_W'(CBS_BUSNUM_RESET)
      && subordinate_bus_number_r == BUS_W'(CBS_BUSNUM_RESET))
    else $error("bus numbers not reset");

  a_secondary_write: assert property (
    @(posedge core_clk) disable iff (!rst_b || !global_reset_n)
    (cfg_wr && hit_busnum && cfg_be[CBS_LANE_SECONDARY])
      |=> secondary_bus_number_r == $past(cfg_wdata[15:8]))
    else $error("secondary bus number not stored");

  a_subord_write: assert property (
    @(posedge core_clk) disable iff (!rst_b || !global_reset_n)
    (cfg_wr && hit_busnum && cfg_be[CBS_LANE_SUBORD])
      |=> subordinate_bus_number_r == $past(cfg_wdata[23:16]))
    else $error("subordinate bus number not stored");

  a_fwd_pass: assert property (
    @(posedge core_clk) disable iff (!rst_b || !global_reset_n)
    (fwd_req && fwd_bus > secondary_bus_number_r && fwd_bus <= subordinate_bus_number_r)
      |=> fwd_pass && !fwd_local && !fwd_drop)
    else $error("in-range bus not passed");

  a_fwd_drop: assert property (
    @(posedge core_clk) disable iff (!rst_b || !global_reset_n)
    (fwd_req && fwd_bus != secondary_bus_number_r
      && (fwd_bus < secondary_bus_number_r || fwd_bus > subordinate_bus_number_r))
      |=> fwd_drop && !fwd_local && !fwd_pass)
    else $error("out-of-range bus not dropped");

  a_fwd_idle: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    !fwd_req |=> !fwd_local && !fwd_pass && !fwd_drop)
    else $error("forward decision without request");

  a_read_pulse: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    cfg_rd |=> cfg_rvalid)
    else $error("read valid missing after read");

endmodule

// File: test/cbs_card_model.sv
// Card side model driving the secondary bus event lines
`timescale 1ns/1ps
module cbs_card_model (
  input  wire logic       evt_go,
  input  wire logic [2:0] evt_code,
  output logic            sec_parity_err,
  output logic            card_serr_n,
  output logic            sec_master_abort,
  output logic            sec_target_abort_in,
  output logic            sec_target_abort_out,
  output logic            card_perr_n,
  output logic            sec_was_master
);
  // Lines idle inactive between events, so no stale pulse leaks through
  always_comb begin
    sec_parity_err       = evt_go && (evt_code == 3'h0);
    card_serr_n          = !(evt_go && (evt_code == 3'h1));
    sec_master_abort     = evt_go && (evt_code == 3'h2);
    sec_target_abort_in  = evt_go && (evt_code == 3'h3);
    sec_target_abort_out = evt_go && (evt_code == 3'h4);
    // Codes 5 and 6 give a card parity error, with and without mastership
    card_perr_n          = !(evt_go && ((evt_code == 3'h5) || (evt_code == 3'h6)));
    sec_was_master       = evt_go && (evt_code == 3'h5);
  end
endmodule

// File: test/test_cardbus_bridge_secondary_status_busnum.sv
// Self-checking bench for the secondary status and bus number registers
`timescale 1ns/1ps
module test_cardbus_bridge_secondary_status_busnum
  import cbs_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        global_reset_n = 1'b0;
  logic        cfg_wr = 1'b0;
  logic        cfg_rd = 1'b0;
  logic [7:0]  cfg_addr = 8'h00;
  logic [3:0]  cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0000_0000;
  logic [31:0] cfg_rdata;
  logic        cfg_rvalid;
  logic        parity_resp_en = 1'b0;
  logic        fwd_req = 1'b0;
  logic [7:0]  fwd_bus = 8'h00;
  logic        fwd_local;
  logic        fwd_pass;
  logic        fwd_drop;
  logic [15:0] sec_status;
  logic        evt_go = 1'b0;
  logic [2:0]  evt_code = 3'h0;
  logic        sec_parity_err;
  logic        card_serr_n;
  logic        sec_master_abort;
  logic        sec_target_abort_in;
  logic        sec_target_abort_out;
  logic        card_perr_n;
  logic        sec_was_master;
  int          mismatches = 0;
  int          tests_run = 0;

  always #10 core_clk = ~core_clk;

  cbs_card_model cbs_card_model_i (
    .evt_go(evt_go), .evt_code(evt_code), .sec_parity_err(sec_parity_err),
    .card_serr_n(card_serr_n), .sec_master_abort(sec_master_abort),
    .sec_target_abort_in(sec_target_abort_in), .sec_target_abort_out(sec_target_abort_out),
    .card_perr_n(card_perr_n), .sec_was_master(sec_was_master)
  );

  cbs_bridge_regs #(.BUS_W(8)) cbs_bridge_regs_i (
    .core_clk(core_clk), .rst_b(rst_b), .global_reset_n(global_reset_n),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .sec_parity_err(sec_parity_err), .card_serr_n(card_serr_n),
    .sec_master_abort(sec_master_abort), .sec_target_abort_in(sec_target_abort_in),
    .sec_target_abort_out(sec_target_abort_out), .card_perr_n(card_perr_n),
    .sec_was_master(sec_was_master), .parity_resp_en(parity_resp_en),
    .fwd_req(fwd_req), .fwd_bus(fwd_bus), .fwd_local(fwd_local), .fwd_pass(fwd_pass),
    .fwd_drop(fwd_drop), .sec_status(sec_status)
  );

  task automatic conclude();
    if (mismatches == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge core_clk);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    @(negedge core_clk);
    cfg_wr = 1'b0;
  endtask

  // Valid stands one cycle only, so look right after the read edge
  // May follow a write directly, reusing its address
  task automatic rd_now(input logic [31:0] exp);
    cfg_rd = 1'b1;
    @(negedge core_clk);
    cfg_rd = 1'b0;
    chk({31'h0, cfg_rvalid}, 32'h1, "read valid");
    chk(cfg_rdata, exp, "read data");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(negedge core_clk);
    cfg_addr = a;
    rd_now(exp);
  endtask

  task automatic evt(input logic [2:0] c);
    @(negedge core_clk);
    evt_go = 1'b1;
    evt_code = c;
    @(negedge core_clk);
    evt_go = 1'b0;
  endtask

  task automatic sts(input logic [15:0] exp);
    chk({16'h0, sec_status}, {16'h0, exp}, "status");
  endtask

  task automatic fwd(input logic [7:0] b, input logic [2:0] exp);
    @(negedge core_clk);
    fwd_req = 1'b1;
    fwd_bus = b;
    @(negedge core_clk);
    fwd_req = 1'b0;
    chk({29'h0, fwd_local, fwd_pass, fwd_drop}, {29'h0, exp}, "forward");
  endtask

  initial begin
    #100000;
    mismatches++;
    conclude();
  end

  initial begin
    repeat (10) @(negedge core_clk);
    rst_b = 1'b1;
    global_reset_n = 1'b1;
    rd(CBS_OFS_BUSNUM_DW, 32'h0000_0000);
    rd(CBS_OFS_STATUS_DW, 32'h0200_0000);
    rd(8'h20, 32'h0000_0000);
    wr(CBS_OFS_BUSNUM_DW, 4'hF, 32'hFF21_0503);
    rd_now(32'h0021_0503);
    wr(CBS_OFS_BUSNUM_DW, 4'h2, 32'hAAAA_07AA);
    rd(CBS_OFS_BUSNUM_DW, 32'h0021_0703);
    // Boundaries around secondary and subordinate numbers
    fwd(8'h07, 3'b100);
    fwd(8'h08, 3'b010);
    fwd(8'h21, 3'b010);
    fwd(8'h22, 3'b001);
    fwd(8'h03, 3'b001);
    fwd(8'h06, 3'b001);
    for (int i = 0; i < 5; i++) begin
      evt(3'(i));
      sts(16'h0200 | (16'h0001 << (15 - i)));
      wr(CBS_OFS_STATUS_DW, 4'hF, 32'h0000_FFFF);
      sts(16'h0200 | (16'h0001 << (15 - i)));
      wr(CBS_OFS_STATUS_DW, 4'h8, 32'h0000_0001 << (31 - i));
      sts(16'h0200);
    end
    parity_resp_en = 1'b1;
    evt(3'h5);
    sts(16'h0300);
    wr(CBS_OFS_STATUS_DW, 4'h8, 32'h0100_0000);
    sts(16'h0200);
    evt(3'h6);
    sts(16'h0200);
    parity_resp_en = 1'b0;
    evt(3'h5);
    sts(16'h0200);
    wr(CBS_OFS_STATUS_DW, 4'hF, 32'hFFFF_FFFF);
    rd(CBS_OFS_STATUS_DW, 32'h0200_0000);
    evt(3'h0);
    evt(3'h3);
    // Local reset must leave the error flags alone
    rst_b = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_b = 1'b1;
    sts(16'h9200);
    rd(CBS_OFS_BUSNUM_DW, 32'h0000_0000);
    global_reset_n = 1'b0;
    @(negedge core_clk);
    global_reset_n = 1'b1;
    sts(16'h0200);
    conclude();
  end
endmodule
